//--- core/can_mask_pkg.sv
package can_mask_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_SEL_LOW   = 8'h00;
  localparam logic [7:0] OFS_SEL_HIGH  = 8'h04;
  localparam logic [7:0] OFS_MSTD0     = 8'h08;
  localparam logic [7:0] OFS_MSTD1     = 8'h0C;
  localparam logic [7:0] OFS_MSTD2     = 8'h10;
  localparam logic [7:0] OFS_MEXT0     = 8'h14;
  localparam logic [7:0] OFS_MEXT1     = 8'h18;
  localparam logic [7:0] OFS_MEXT2     = 8'h1C;
  localparam logic [7:0] OFS_LAST_HIT  = 8'h20;

  // ****************************************
  // Reset values and field layout
  // ****************************************
  localparam logic [15:0] SEL_RESET      = 16'h0000;
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [15:0] STD_IMPL_BITS  = 16'hFFEB;
  localparam int          SID_MSB        = 15;
  localparam int          SID_LSB        = 5;
  localparam int          TYPE_BIT       = 3;
  localparam int          NUM_MASKS      = 3;
  localparam int          NUM_FILTERS    = 16;
  localparam int          FILT_PER_SEL   = 8;

  // ****************************************
  // Mask source encoding
  // ****************************************
  localparam logic [1:0] SRC_MASK0    = 2'b00;
  localparam logic [1:0] SRC_MASK1    = 2'b01;
  localparam logic [1:0] SRC_MASK2    = 2'b10;
  localparam logic [1:0] SRC_RESERVED = 2'b11;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        ide;
    logic [10:0] sid;
    logic [17:0] eid;
  } rx_frame_t;

endpackage

//--- core/can_acceptance_mask_select.sv
`timescale 1ns/1ps
// Operation
// R1 - Each filter has a 2-bit mask source: 00 mask 0, 01 mask 1, 10 mask 2, 11 reserved.
// R2 - The low selection register holds filters 7..0, filter 7 in bits 15-14, filter 0 in 1-0.
// R3 - The high selection register holds filters 15..8 packed the same way.
// R4 - Three mask sets exist, each with a standard and an extended mask word.
// R5 - A one in a standard mask bit makes that identifier bit compared, a zero don't-care.
// R6 - Mask bits 17 and 16 in the low bits of the standard word include or exclude those bits.
// R7 - With the type match bit set, the frame type must equal the filter extended setting.
// R8 - With the type match bit clear, either frame type passes when masked bits agree.
// R9 - Unimplemented standard mask bits read zero and ignore writes.
// R10 - Every compared identifier bit must equal the filter's stored bit.
// R11 - The extended mask word covers bits 15..0, one compared, zero don't-care.
// R12 - A hit needs all enabled bits equal and the type condition met.
module can_acceptance_mask_select (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   rx_valid,
  input  wire can_mask_pkg::rx_frame_t rx_frame,
  input  wire logic [15:0]            filter_std_id_word [16],
  input  wire logic [15:0]            filter_ext_id_word [16],
  output logic [15:0]                 filter_hit,
  output logic                        hit_valid
);

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] filter_mask_select_low;
  logic [15:0] filter_mask_select_high;
  logic [15:0] acceptance_mask_std_id [3];
  logic [15:0] acceptance_mask_ext_id [3];
  logic [15:0] last_hit;
  logic [7:0]  aw_addr;
  logic [7:0]  rd_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        wr_do;
  logic [15:0] next_hit;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [1:0] filter_mask_source(input logic [15:0] lo,
                                                    input logic [15:0] hi,
                                                    input int          idx);
    logic [15:0] word;
    int          pos;
    word = (idx < can_mask_pkg::FILT_PER_SEL) ? lo : hi;
    pos  = (idx % can_mask_pkg::FILT_PER_SEL) * 2;
    return word[pos +: 2]; // R2 R3
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  function automatic logic filter_match(input logic [15:0]            fstd,
                                        input logic [15:0]            fext,
                                        input logic [15:0]            mstd,
                                        input logic [15:0]            mext,
                                        input can_mask_pkg::rx_frame_t f);
    logic [10:0] sid_care;
    logic [17:0] eid_care;
    logic        sid_ok;
    logic        eid_ok;
    logic        type_ok;
    sid_care = mstd[can_mask_pkg::SID_MSB:can_mask_pkg::SID_LSB]; // R5
    eid_care = {mstd[1:0], mext}; // R6 R11
    sid_ok   = ((fstd[can_mask_pkg::SID_MSB:can_mask_pkg::SID_LSB] ^ f.sid)
                & sid_care) == 11'h000; // R10
    eid_ok   = (({fstd[1:0], fext} ^ f.eid) & eid_care) == 18'h0_0000; // R10
    type_ok  = !mstd[can_mask_pkg::TYPE_BIT]
               || (f.ide == fstd[can_mask_pkg::TYPE_BIT]); // R7 R8
    return sid_ok && (eid_ok || !f.ide) && type_ok; // R12
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= can_mask_pkg::OFS_LAST_HIT);
  endfunction

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign wr_do = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b0;
      aw_addr       <= 8'h00;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_held       <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (!aw_held) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_held       <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (!w_held) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= can_mask_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_addr(aw_addr) ? can_mask_pkg::RESP_OKAY
                                          : can_mask_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_mask_select_low  <= can_mask_pkg::SEL_RESET;
      filter_mask_select_high <= can_mask_pkg::SEL_RESET;
    end else if (wr_do && aw_addr == can_mask_pkg::OFS_SEL_LOW) begin
      filter_mask_select_low <= merge16(filter_mask_select_low, w_data, w_strb); // R2
    end else if (wr_do && aw_addr == can_mask_pkg::OFS_SEL_HIGH) begin
      filter_mask_select_high <= merge16(filter_mask_select_high, w_data, w_strb); // R3
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int m = 0; m < can_mask_pkg::NUM_MASKS; m++) begin
        acceptance_mask_std_id[m] <= can_mask_pkg::MASK_RESET;
        acceptance_mask_ext_id[m] <= can_mask_pkg::MASK_RESET;
      end
    end else if (wr_do) begin
      for (int m = 0; m < can_mask_pkg::NUM_MASKS; m++) begin
        if (aw_addr == can_mask_pkg::OFS_MSTD0 + 8'(4 * m)) begin
          acceptance_mask_std_id[m] <= merge16(acceptance_mask_std_id[m], w_data, w_strb)
                                       & can_mask_pkg::STD_IMPL_BITS; // R4 R9
        end
        if (aw_addr == can_mask_pkg::OFS_MEXT0 + 8'(4 * m)) begin
          acceptance_mask_ext_id[m] <= merge16(acceptance_mask_ext_id[m], w_data, w_strb); // R4
        end
      end
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= can_mask_pkg::RESP_OKAY;
      rd_addr       <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      rd_addr       <= s_axi_araddr;
      s_axi_rresp   <= known_addr(s_axi_araddr) ? can_mask_pkg::RESP_OKAY
                                                : can_mask_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        can_mask_pkg::OFS_SEL_LOW:  s_axi_rdata <= {16'h0000, filter_mask_select_low};
        can_mask_pkg::OFS_SEL_HIGH: s_axi_rdata <= {16'h0000, filter_mask_select_high};
        can_mask_pkg::OFS_MSTD0:    s_axi_rdata <= {16'h0000, acceptance_mask_std_id[0]};
        can_mask_pkg::OFS_MSTD1:    s_axi_rdata <= {16'h0000, acceptance_mask_std_id[1]};
        can_mask_pkg::OFS_MSTD2:    s_axi_rdata <= {16'h0000, acceptance_mask_std_id[2]};
        can_mask_pkg::OFS_MEXT0:    s_axi_rdata <= {16'h0000, acceptance_mask_ext_id[0]};
        can_mask_pkg::OFS_MEXT1:    s_axi_rdata <= {16'h0000, acceptance_mask_ext_id[1]};
        can_mask_pkg::OFS_MEXT2:    s_axi_rdata <= {16'h0000, acceptance_mask_ext_id[2]};
        can_mask_pkg::OFS_LAST_HIT: s_axi_rdata <= {16'h0000, last_hit};
        default:                    s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Acceptance comparison
  // ****************************************
  always_comb begin
    next_hit = 16'h0000;
    for (int i = 0; i < can_mask_pkg::NUM_FILTERS; i++) begin
      logic [1:0] src;
      src = filter_mask_source(filter_mask_select_low, filter_mask_select_high, i);
      if (src != can_mask_pkg::SRC_RESERVED) begin // R1
        next_hit[i] = filter_match(filter_std_id_word[i], filter_ext_id_word[i],
                                   acceptance_mask_std_id[src],
                                   acceptance_mask_ext_id[src], rx_frame); // R12
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filter_hit <= 16'h0000;
      hit_valid  <= 1'b0;
      last_hit   <= 16'h0000;
    end else begin
      hit_valid  <= rx_valid;
      filter_hit <= rx_valid ? next_hit : 16'h0000;
      if (rx_valid) begin
        last_hit <= next_hit;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_reserved_src;
    @(posedge aclk) disable iff (!aresetn)
    rx_valid && filter_mask_select_low[1:0] == can_mask_pkg::SRC_RESERVED |=> !filter_hit[0];
  endproperty
  a_reserved_src: assert property (p_reserved_src) else $error("reserved source hit"); // R1

  property p_sel_low_write;
    @(posedge aclk) disable iff (!aresetn)
    wr_do && aw_addr == can_mask_pkg::OFS_SEL_LOW && w_strb[1:0] == 2'b11
    |=> filter_mask_select_low == $past(w_data[15:0]);
  endproperty
  a_sel_low_write: assert property (p_sel_low_write) else $error("low select lost"); // R2

  property p_sel_high_write;
    @(posedge aclk) disable iff (!aresetn)
    wr_do && aw_addr == can_mask_pkg::OFS_SEL_HIGH && w_strb[1:0] == 2'b11
    |=> filter_mask_select_high == $past(w_data[15:0]) && $stable(filter_mask_select_low);
  endproperty
  a_sel_high_write: assert property (p_sel_high_write) else $error("high select lost"); // R3

  property p_mask_indep;
    @(posedge aclk) disable iff (!aresetn)
    wr_do && aw_addr == can_mask_pkg::OFS_MSTD1 |=> $stable(acceptance_mask_std_id[0]);
  endproperty
  a_mask_indep: assert property (p_mask_indep) else $error("mask sets coupled"); // R4

  property p_sid_dont_care;
    @(posedge aclk) disable iff (!aresetn)
    rx_valid && !rx_frame.ide && filter_mask_select_low[1:0] == can_mask_pkg::SRC_MASK0
    && acceptance_mask_std_id[0] == 16'h0000 |=> filter_hit[0];
  endproperty
  a_sid_dont_care: assert property (p_sid_dont_care) else $error("open mask missed"); // R5 R8

  property p_ext_dont_care;
    @(posedge aclk) disable iff (!aresetn)
    rx_valid && rx_frame.ide && filter_mask_select_low[1:0] == can_mask_pkg::SRC_MASK0
    && acceptance_mask_std_id[0] == 16'h0000 && acceptance_mask_ext_id[0] == 16'h0000
    |=> filter_hit[0];
  endproperty
  a_ext_dont_care: assert property (p_ext_dont_care) else $error("ext open missed"); // R6 R11

  property p_type_mismatch;
    @(posedge aclk) disable iff (!aresetn)
    rx_valid && filter_mask_select_low[1:0] == can_mask_pkg::SRC_MASK0
    && acceptance_mask_std_id[0][3] && rx_frame.ide != filter_std_id_word[0][3]
    |=> !filter_hit[0];
  endproperty
  a_type_mismatch: assert property (p_type_mismatch) else $error("type not enforced"); // R7

  property p_std_read_zero;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && rd_addr >= can_mask_pkg::OFS_MSTD0 && rd_addr <= can_mask_pkg::OFS_MSTD2
    |-> s_axi_rdata[4] == 1'b0 && s_axi_rdata[2] == 1'b0 && s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_std_read_zero: assert property (p_std_read_zero) else $error("unimpl bit read"); // R9

  property p_sid_compare;
    @(posedge aclk) disable iff (!aresetn)
    rx_valid && filter_mask_select_low[1:0] == can_mask_pkg::SRC_MASK0
    && acceptance_mask_std_id[0][15:5] == 11'h7FF && rx_frame.sid != filter_std_id_word[0][15:5]
    |=> !filter_hit[0];
  endproperty
  a_sid_compare: assert property (p_sid_compare) else $error("sid mismatch hit"); // R10

  property p_hit_needs_valid;
    @(posedge aclk) disable iff (!aresetn)
    filter_hit != 16'h0000 |-> hit_valid && $past(rx_valid);
  endproperty
  a_hit_needs_valid: assert property (p_hit_needs_valid) else $error("stray hit"); // R12

  c_write: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready);
  c_hit: cover property (@(posedge aclk) disable iff (!aresetn)
    hit_valid && filter_hit[15]);

endmodule

//--- testbench/can_rx_engine_model.sv
`timescale 1ns/1ps
// ****************************************
// Receive path of the protocol engine
// ****************************************
module can_rx_engine_model (
  input  wire logic         aclk,
  output logic              rx_valid,
  output can_mask_pkg::rx_frame_t rx_frame
);
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end

  // One identifier per pulse; the bus shows junk between frames
  task automatic send(input can_mask_pkg::rx_frame_t f);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
endmodule

//--- testbench/can_acceptance_mask_select_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module can_acceptance_mask_select_bench;
  // ****************************************
  // Signals
  // ****************************************
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_valid, hit_valid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] filter_hit;
  logic [15:0] fstd [16];
  logic [15:0] fext [16];
  logic [15:0] sel  [2];
  logic [15:0] mstd [3];
  logic [15:0] mext [3];
  can_mask_pkg::rx_frame_t rx_frame;
  int          failures, n_checks;

  can_acceptance_mask_select i_can_acceptance_mask_select (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .filter_std_id_word(fstd),
    .filter_ext_id_word(fext), .filter_hit(filter_hit), .hit_valid(hit_valid));

  can_rx_engine_model i_can_rx_engine_model (
    .aclk(aclk), .rx_valid(rx_valid), .rx_frame(rx_frame));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'h3;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        bready <= 1'b0;
        `CHK(bresp, er)
      end
    end
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rready <= 1'b0;
        `CHK(rdata, e)
        `CHK(rresp, er)
      end
    end
  endtask

  task automatic set_mask(input int m, input logic [15:0] s, input logic [15:0] x);
    wr(can_mask_pkg::OFS_MSTD0 + 8'(4 * m), {16'h0000, s}, can_mask_pkg::RESP_OKAY);
    wr(can_mask_pkg::OFS_MEXT0 + 8'(4 * m), {16'h0000, x}, can_mask_pkg::RESP_OKAY);
    mstd[m] = s & can_mask_pkg::STD_IMPL_BITS;
    mext[m] = x;
  endtask

  task automatic set_sel(input logic [15:0] lo, input logic [15:0] hi);
    wr(can_mask_pkg::OFS_SEL_LOW, {16'h0000, lo}, can_mask_pkg::RESP_OKAY);
    wr(can_mask_pkg::OFS_SEL_HIGH, {16'h0000, hi}, can_mask_pkg::RESP_OKAY);
    sel[0] = lo;
    sel[1] = hi;
  endtask

  // ****************************************
  // Reference of the filter hits
  // ****************************************
  function automatic logic [15:0] exp_hit(can_mask_pkg::rx_frame_t f);
    logic [15:0] h, ms, fs;
    logic [1:0]  s;
    logic        ok;
    h = '0;
    for (int i = 0; i < 16; i++) begin
      s = sel[i / 8][2 * (i % 8) +: 2];
      if (s != 2'b11) begin
        ms = mstd[s];
        fs = fstd[i];
        ok = ((f.sid ^ fs[15:5]) & ms[15:5]) == 0;
        if (f.ide) ok &= ((f.eid ^ {fs[1:0], fext[i]}) & {ms[1:0], mext[s]}) == 0;
        if (ms[3]) ok &= f.ide == fs[3];
        h[i] = ok;
      end
    end
    return h;
  endfunction

  task automatic frame(input logic ide, input int k, input logic [17:0] flip);
    can_mask_pkg::rx_frame_t f;
    logic [15:0] e;
    f.ide = ide;
    f.sid = fstd[k][15:5];
    f.eid = {fstd[k][1:0], fext[k]} ^ flip;
    e = exp_hit(f);
    i_can_rx_engine_model.send(f);
    #1;
    `CHK(hit_valid, 1'b1)
    `CHK(filter_hit, e)
    chk_rd(can_mask_pkg::OFS_LAST_HIT, {16'h0000, e}, can_mask_pkg::RESP_OKAY);
  endtask

  task automatic run_frames();
    for (int k = 0; k < 16; k++) begin
      frame(1'b0, k, 18'h0_0000);
      frame(1'b1, k, (k % 3 == 1) ? 18'h0_0001 : (k % 3 == 2) ? 18'h1_0000 : 18'h0);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk_rd(can_mask_pkg::OFS_SEL_LOW, 32'h0000_0000, can_mask_pkg::RESP_OKAY);
    chk_rd(can_mask_pkg::OFS_SEL_HIGH, 32'h0000_0000, can_mask_pkg::RESP_OKAY);
    for (int m = 0; m < 3; m++) begin
      chk_rd(can_mask_pkg::OFS_MSTD0 + 8'(4 * m), 32'h0, can_mask_pkg::RESP_OKAY);
      chk_rd(can_mask_pkg::OFS_MEXT0 + 8'(4 * m), 32'h0, can_mask_pkg::RESP_OKAY);
    end
    chk_rd(8'h24, 32'h0000_0000, can_mask_pkg::RESP_SLVERR);
    chk_rd(8'h02, 32'h0000_0000, can_mask_pkg::RESP_SLVERR);
    wr(8'h24, 32'h0000_1234, can_mask_pkg::RESP_SLVERR);
  endtask

  task automatic t_unimpl();
    set_mask(1, 16'hFFFF, 16'hFFFF);
    chk_rd(can_mask_pkg::OFS_MSTD1, 32'h0000_FFEB, can_mask_pkg::RESP_OKAY);
    chk_rd(can_mask_pkg::OFS_MEXT1, 32'h0000_FFFF, can_mask_pkg::RESP_OKAY);
  endtask

  task automatic t_select();
    set_sel(16'hE4E4, 16'h1B1B);
    chk_rd(can_mask_pkg::OFS_SEL_LOW, 32'h0000_E4E4, can_mask_pkg::RESP_OKAY);
    chk_rd(can_mask_pkg::OFS_SEL_HIGH, 32'h0000_1B1B, can_mask_pkg::RESP_OKAY);
    set_mask(0, 16'hFFE0, 16'h0000);
    set_mask(1, 16'h0000, 16'h0000);
    set_mask(2, 16'hFFE3, 16'hFFFF);
    run_frames();
  endtask

  task automatic t_type();
    set_sel(16'h0000, 16'h5555);
    set_mask(0, 16'hFFE8, 16'h0000);
    run_frames();
    set_sel(16'hFFFF, 16'h5555);
    frame(1'b1, 3, 18'h0_0000);
    chk_rd(can_mask_pkg::OFS_LAST_HIT, 32'h0000_FF00, can_mask_pkg::RESP_OKAY);
    set_mask(0, 16'h0000, 16'h0000);
    set_sel(16'h0000, 16'hFFFF);
    frame(1'b0, 5, 18'h0_0000);
    frame(1'b1, 5, 18'h3_FFFF);
    chk_rd(can_mask_pkg::OFS_LAST_HIT, 32'h0000_00FF, can_mask_pkg::RESP_OKAY);
  endtask

  task automatic t_rerun();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(can_mask_pkg::OFS_SEL_LOW, 32'h0000_0000, can_mask_pkg::RESP_OKAY);
    chk_rd(can_mask_pkg::OFS_MSTD0, 32'h0000_0000, can_mask_pkg::RESP_OKAY);
    chk_rd(can_mask_pkg::OFS_LAST_HIT, 32'h0000_0000, can_mask_pkg::RESP_OKAY);
  endtask

  task automatic close_out();
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    close_out();
  end

  initial begin
    aresetn = 1'b0;
    awaddr  = '0;
    awvalid = 1'b0;
    wdata   = '0;
    wstrb   = '0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = '0;
    arvalid = 1'b0;
    rready  = 1'b0;
    for (int i = 0; i < 16; i++) begin
      fstd[i] = {11'h100 + 11'(i % 8), 1'b0, (i % 3 == 0), 1'b0, 2'(i)};
      fext[i] = 16'hA5A0 + 16'(i);
    end
    for (int m = 0; m < 3; m++) begin
      mstd[m] = '0;
      mext[m] = '0;
    end
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_unimpl();
    t_select();
    t_type();
    t_rerun();
    close_out();
  end
endmodule
